// ==== rtl/dbwlm_pkg.sv ====
// Package for the DMA bandwidth limiter and monitor: register map, fields, reset values
package dbwlm_pkg;
    // ***************************
    // Register byte offsets
    // ***************************
    localparam logic [7:0] DBWLM_OFS_CFG = 8'h00;
    localparam logic [7:0] DBWLM_OFS_SPACING = 8'h04;
    localparam logic [7:0] DBWLM_OFS_BUDGET = 8'h08;
    localparam logic [7:0] DBWLM_OFS_CURRENT = 8'h0C;
    localparam logic [7:0] DBWLM_OFS_STATUS = 8'h10;
    // ***************************
    // Fields
    // ***************************
    localparam int DBWLM_CFG_EN_BIT = 0;
    localparam int DBWLM_CFG_SIZE_LSB = 4;
    localparam int DBWLM_STAT_IRQERR_BIT = 0;
    localparam int DBWLM_STAT_ERRC_LSB = 4;
    localparam int DBWLM_STAT_RUN_BIT = 8;
    localparam logic [3:0] DBWLM_ERRC_NONE = 4'h0;
    localparam logic [3:0] DBWLM_ERRC_ALIGN = 4'h1;
    localparam logic [3:0] DBWLM_ERRC_BWMON = 4'h6;
    // ***************************
    // Special values and reset values
    // ***************************
    localparam logic [15:0] DBWLM_SPACING_FREE = 16'h0000;
    localparam logic [15:0] DBWLM_SPACING_STOP = 16'hFFFF;
    localparam logic [15:0] DBWLM_SPACING_RST = 16'h0000;
    localparam logic [31:0] DBWLM_BUDGET_RST = 32'h00000000;
    localparam logic [31:0] DBWLM_BUDGET_OFF = 32'h00000000;
    localparam logic [2:0] DBWLM_SIZE_RST = 3'h0;
    localparam logic [2:0] DBWLM_SIZE_MAX = 3'h5;
    localparam logic [1:0] DBWLM_RESP_OKAY = 2'h0;
    localparam logic [1:0] DBWLM_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/dbwlm_channel.sv ====
// Bandwidth limiter and bandwidth monitor for one memory-to-memory DMA channel
`timescale 1ns/10ps
// Operation
// - Every memory-to-memory channel, pipe and compositor channels included, carries this limiter and monitor.
// - The spacing count gives the number of clock cycles between two consecutive requests.
// - A spacing count of zero lets the channel request as often as it can.
// - A spacing count of all ones stops all requests.
// - Throughput never exceeds clock rate times transfer size over the spacing count.
// - The budget is copied into the current counter on a config write, at work unit end, or on autobuffer wrap.
// - The current counter decrements once per cycle while a work unit is active.
// - Reaching zero before the work unit ends sets the error flag and cause code six.
// - After expiry the counter holds at zero without re-signalling until reload.
// - A monitor expiry never halts or aborts the work unit.
// - A budget of zero disables the monitor entirely.
// - Transfer size is selectable among 1, 2, 4, 8, 16 and 32 bytes.
// - A start address not aligned to the transfer size raises the error flag.
module dbwlm_channel
    import dbwlm_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // ***************************
    // Clock and reset
    // ***************************
    input wire logic clk_sys,
    input wire logic resetn,
    // ***************************
    // AXI4-Lite slave
    // ***************************
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // ***************************
    // Channel engine side
    // ***************************
    input wire logic workStart,
    input wire logic [ADDR_W-1:0] workStartAddr,
    input wire logic workActive,
    input wire logic workEnd,
    input wire logic autobufWrap,
    input wire logic engineReq,
    // ***************************
    // Crossbar request side
    // ***************************
    output logic reqAllowed,
    output logic xbarReq,
    output logic errorIrq,
    output logic [2:0] memoryTransferSize
);
    // ***************************
    // Decode helpers
    // ***************************
    function automatic logic hitWord(input logic [7:0] addr, input logic [7:0] ofs);
        hitWord = (addr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic misaligned(input logic [ADDR_W-1:0] addr, input logic [2:0] sz);
        logic [5:0] mask;
        mask = 6'(6'h01 << sz) - 6'h01;
        misaligned = |(addr[5:0] & mask);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hitWord(addr, DBWLM_OFS_CFG) | hitWord(addr, DBWLM_OFS_SPACING) |
                 hitWord(addr, DBWLM_OFS_BUDGET) | hitWord(addr, DBWLM_OFS_CURRENT) |
                 hitWord(addr, DBWLM_OFS_STATUS);
    endfunction

    // ***************************
    // Register state
    // ***************************
    logic [2:0] sizeReg;
    logic enableReg;
    logic [15:0] spacingReg;
    logic [31:0] budgetReg;
    logic [31:0] currentReg;
    logic irqErrReg;
    logic [3:0] errCauseReg;
    logic expiredReg;
    logic [15:0] gapReg;
    logic [15:0] gapNext;

    logic awHeld, wHeld;
    logic [7:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic doWrite;
    logic cfgWrite;
    logic stsClear;
    logic issue;
    logic monExpire;
    logic reloadNow;
    logic alignFault;
    logic [31:0] currentNext;
    logic expiredNext;
    logic [31:0] rdataNext;

    // ***************************
    // Derived strobes
    // ***************************
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign cfgWrite = doWrite && hitWord(awAddrReg, DBWLM_OFS_CFG);
    assign stsClear = doWrite && hitWord(awAddrReg, DBWLM_OFS_STATUS) &&
                      wStrbReg[0] && wDataReg[DBWLM_STAT_IRQERR_BIT];
    assign reloadNow = cfgWrite || workEnd || autobufWrap;
    assign alignFault = workStart && misaligned(workStartAddr, sizeReg);

    // ***************************
    // Write channel
    // ***************************
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 8'h00;
            wDataReg <= 32'h00000000;
            wStrbReg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DBWLM_RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddrReg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddrReg) ? DBWLM_RESP_OKAY : DBWLM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
        end
    end

    // ***************************
    // Configuration registers
    // ***************************
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sizeReg <= DBWLM_SIZE_RST;
            enableReg <= 1'b0;
            spacingReg <= DBWLM_SPACING_RST;
            budgetReg <= DBWLM_BUDGET_RST;
        end else if (doWrite) begin
            if (hitWord(awAddrReg, DBWLM_OFS_CFG) && wStrbReg[0]) begin
                enableReg <= wDataReg[DBWLM_CFG_EN_BIT];
                // Codes above 32 bytes clamp so the alignment mask stays in range
                if (wDataReg[DBWLM_CFG_SIZE_LSB +: 3] > DBWLM_SIZE_MAX) begin
                    sizeReg <= DBWLM_SIZE_MAX;
                end else begin
                    sizeReg <= wDataReg[DBWLM_CFG_SIZE_LSB +: 3];
                end
            end
            if (hitWord(awAddrReg, DBWLM_OFS_SPACING)) begin
                if (wStrbReg[0]) spacingReg[7:0] <= wDataReg[7:0];
                if (wStrbReg[1]) spacingReg[15:8] <= wDataReg[15:8];
            end
            if (hitWord(awAddrReg, DBWLM_OFS_BUDGET)) begin
                for (int i = 0; i < 4; i++) begin
                    if (wStrbReg[i]) budgetReg[8*i +: 8] <= wDataReg[8*i +: 8];
                end
            end
        end
    end

    // ***************************
    // Request limiter
    // ***************************
    // Spacing in force for every memory-to-memory channel instance
    assign issue = engineReq && reqAllowed && enableReg;

    always_comb begin
        gapNext = gapReg;
        if (issue) begin
            // Reload takes one cycle off so requests land exactly count cycles apart
            if (spacingReg == DBWLM_SPACING_FREE) begin
                gapNext = 16'h0000;
            end else begin
                gapNext = spacingReg - 16'h0001;
            end
        end else if (gapReg > spacingReg) begin
            gapNext = spacingReg; // Shrinking the count takes effect at once
        end else if (gapReg != 16'h0000) begin
            gapNext = gapReg - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gapReg <= 16'h0000;
        end else begin
            gapReg <= gapNext;
        end
    end

    // A request granted just before a stop code lands still reaches the crossbar
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reqAllowed <= 1'b0;
            xbarReq <= 1'b0;
        end else begin
            // Look-ahead: allowed exactly when the gap will stand at zero, never when stopped
            reqAllowed <= (spacingReg != DBWLM_SPACING_STOP) &&
                          ((spacingReg == DBWLM_SPACING_FREE) ||
                           (gapNext == 16'h0000));
            xbarReq <= issue;
        end
    end

    // ***************************
    // Bandwidth monitor
    // ***************************
    assign monExpire = workActive && !expiredReg && (budgetReg != DBWLM_BUDGET_OFF) &&
                       (currentReg == 32'h00000001 || currentReg == 32'h00000000);

    // Reload wins over counting so a fresh budget is never short by a cycle
    always_comb begin
        currentNext = currentReg;
        expiredNext = expiredReg;
        if (reloadNow) begin
            currentNext = budgetReg;
            expiredNext = 1'b0;
        end else if (workActive && budgetReg != DBWLM_BUDGET_OFF) begin
            if (currentReg != 32'h00000000) begin
                currentNext = currentReg - 32'h00000001;
            end
            if (monExpire) begin
                expiredNext = 1'b1; // Holds at zero, single report
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            currentReg <= DBWLM_BUDGET_RST;
            expiredReg <= 1'b0;
        end else begin
            currentReg <= currentNext;
            expiredReg <= expiredNext;
        end
    end

    // Expiry only reports; the engine's own work unit is never stopped here
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irqErrReg <= 1'b0;
            errCauseReg <= DBWLM_ERRC_NONE;
        end else if (monExpire) begin
            irqErrReg <= 1'b1;
            errCauseReg <= DBWLM_ERRC_BWMON;
        end else if (alignFault) begin
            irqErrReg <= 1'b1;
            errCauseReg <= DBWLM_ERRC_ALIGN;
        end else if (stsClear) begin
            // Set beats clear: checked first above
            irqErrReg <= 1'b0;
            errCauseReg <= DBWLM_ERRC_NONE;
        end
    end

    // ***************************
    // Registered outputs
    // ***************************
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            errorIrq <= 1'b0;
            memoryTransferSize <= DBWLM_SIZE_RST;
        end else begin
            errorIrq <= irqErrReg;
            memoryTransferSize <= sizeReg;
        end
    end

    // ***************************
    // Read channel
    // ***************************
    // Unmapped words read as zero alongside the error response
    always_comb begin
        rdataNext = 32'h00000000;
        if (hitWord(s_axi_araddr, DBWLM_OFS_CFG)) begin
            rdataNext[DBWLM_CFG_EN_BIT] = enableReg;
            rdataNext[DBWLM_CFG_SIZE_LSB +: 3] = sizeReg;
        end
        if (hitWord(s_axi_araddr, DBWLM_OFS_SPACING)) begin
            rdataNext[15:0] = spacingReg;
        end
        if (hitWord(s_axi_araddr, DBWLM_OFS_BUDGET)) begin
            rdataNext = budgetReg;
        end
        if (hitWord(s_axi_araddr, DBWLM_OFS_CURRENT)) begin
            rdataNext = currentReg;
        end
        if (hitWord(s_axi_araddr, DBWLM_OFS_STATUS)) begin
            rdataNext[DBWLM_STAT_IRQERR_BIT] = irqErrReg;
            rdataNext[DBWLM_STAT_ERRC_LSB +: 4] = errCauseReg;
            rdataNext[DBWLM_STAT_RUN_BIT] = workActive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= DBWLM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? DBWLM_RESP_OKAY : DBWLM_RESP_SLVERR;
                s_axi_rdata <= rdataNext;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/dbwlm_properties.sv ====
// Port-level assertions for the bandwidth limiter and monitor channel
`timescale 1ns/10ps
module dbwlm_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Engine and crossbar
    input wire logic workStart,
    input wire logic workActive,
    input wire logic engineReq,
    input wire logic reqAllowed,
    input wire logic xbarReq,
    input wire logic errorIrq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence wrBoth; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence respWait; s_axi_bvalid && !s_axi_bready; endsequence
    sequence readWait; s_axi_rvalid && !s_axi_rready; endsequence
    chk_issue_needs_grant: assert property (
        xbarReq |-> $past(reqAllowed && engineReq)) else $error("request without grant");
    chk_gap_blocks_req: assert property (
        !reqAllowed |=> !xbarReq) else $error("request inside spacing gap");
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready stuck");
    chk_b_follows_wr: assert property (wrBoth |=> ##1 s_axi_bvalid) else $error("no write response");
    chk_b_holds: assert property (
        respWait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_r_follows_ar: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    chk_r_holds: assert property (
        readWait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_irq_has_cause: assert property (
        $rose(errorIrq) |-> $past(workActive, 2) || $past(workStart, 2))
        else $error("error flag without cause");
    chk_irq_clear_wr: assert property (
        $fell(errorIrq) |-> $past(s_axi_bvalid)) else $error("error flag lost without clear");
endmodule

// ==== bench/dbwlm_xbar_model.sv ====
// Crossbar-side model: takes every request and measures spacing between them
`timescale 1ns/10ps
module dbwlm_xbar_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Request side
    input wire logic xbarReq,
    input wire logic clearStats,
    // Statistics
    output int reqCount,
    output int lastGap,
    output int minGap
);
    int cyc;
    // No grant wire exists, so every request is accepted at once
    always_ff @(posedge clk_sys) begin
        if (!resetn || clearStats) begin
            reqCount <= 0;
            cyc <= 0;
            lastGap <= 0;
            minGap <= 99999;
        end else begin
            cyc <= cyc + 1;
            if (xbarReq) begin
                reqCount <= reqCount + 1;
                cyc <= 1;
                if (reqCount > 0) begin
                    lastGap <= cyc;
                    if (cyc < minGap) minGap <= cyc;
                end
            end
        end
    end
endmodule

// ==== bench/dma_bandwidth_limit_monitor_tb.sv ====
// Self-checking bench for the bandwidth limiter and monitor channel
`timescale 1ns/10ps
module dma_bandwidth_limit_monitor_tb;
    import dbwlm_pkg::*;
    logic clk_sys = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, workStart = 0, workActive = 0, workEnd = 0;
    logic autobufWrap = 0, engineReq = 0, clearStats = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, workStartAddr = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic reqAllowed, xbarReq, errorIrq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] memoryTransferSize;
    int reqCount, lastGap, minGap, n, sp, err_count = 0, num_checks = 0, seed = 39805;
    dbwlm_channel DUT (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .workStart, .workStartAddr, .workActive,
        .workEnd, .autobufWrap, .engineReq, .reqAllowed, .xbarReq, .errorIrq,
        .memoryTransferSize);
    dbwlm_xbar_model XBAR (.clk_sys, .resetn, .xbarReq, .clearStats, .reqCount, .lastGap,
        .minGap);
    initial forever #2.5 clk_sys = ~clk_sys;
    function automatic int gapExp(input int s);
        return (s == 0) ? 1 : s;
    endfunction
    function automatic logic [2:0] sizeExp(input int c);
        return (c > 5) ? DBWLM_SIZE_MAX : c[2:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // Strobe 0 ends work, 1 wraps autobuffer, 2 starts work, 3 clears model stats
    task automatic strobe(input int s);
        @(posedge clk_sys);
        {workEnd, autobufWrap, workStart, clearStats} <= 4'h8 >> s;
        @(posedge clk_sys);
        {workEnd, autobufWrap, workStart, clearStats} <= 4'h0;
    endtask
    task automatic act(input int k);
        @(posedge clk_sys);
        workActive <= 1;
        tick(k);
        workActive <= 0;
    endtask
    // Ready and answers are looked at on the falling edge, where they are settled
    // Waits have no limit of their own: only the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {ah, wh} = 2'h0;
        while (!(ah && wh)) begin
            @(negedge clk_sys);
            ah = ah || s_axi_awready;
            wh = wh || s_axi_wready;
            @(posedge clk_sys);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        do begin @(negedge clk_sys); end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        @(posedge clk_sys);
        s_axi_bready <= 0;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin @(negedge clk_sys); end while (!s_axi_arready);
        @(posedge clk_sys);
        s_axi_arvalid <= 0;
        do begin @(negedge clk_sys); end while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        @(posedge clk_sys);
        s_axi_rready <= 0;
    endtask
    initial begin
        tick(20);
        resetn <= 1;
        rdReg(DBWLM_OFS_BUDGET);
        check(rd, DBWLM_BUDGET_RST);
        rdReg(8'h14);
        check(rs, DBWLM_RESP_SLVERR);
        wr(8'h18, 32'h1);
        check(rs, DBWLM_RESP_SLVERR);
        for (n = 0; n < 8; n++) begin
            wr(DBWLM_OFS_CFG, 32'h1 | (n << 4));
            tick(2);
            check(memoryTransferSize, sizeExp(n));
        end
        // Random spacings beyond the two boundary codes
        for (n = 0; n < 5; n++) begin
            sp = (n < 2) ? n : 2 + ($random(seed) & 7);
            wr(DBWLM_OFS_SPACING, sp);
            strobe(3);
            engineReq <= 1;
            tick(40);
            engineReq <= 0;
            tick(2);
            check(lastGap, gapExp(sp));
            check(minGap, gapExp(sp));
        end
        wr(DBWLM_OFS_SPACING, DBWLM_SPACING_STOP);
        strobe(3);
        engineReq <= 1;
        tick(60);
        @(negedge clk_sys);
        check({reqAllowed, reqCount[30:0]}, 0);
        wr(DBWLM_OFS_SPACING, DBWLM_SPACING_FREE);
        wr(DBWLM_OFS_BUDGET, 10);
        wr(DBWLM_OFS_CFG, 32'h51);
        rdReg(DBWLM_OFS_CURRENT);
        check(rd, 10);
        act(9);
        rdReg(DBWLM_OFS_CURRENT);
        check({rd, errorIrq}, {32'h1, 1'b0});
        act(1);
        strobe(3);
        act(6);
        rdReg(DBWLM_OFS_STATUS);
        check({rd[7:4], rd[0], errorIrq}, {DBWLM_ERRC_BWMON, 2'h3});
        check(reqCount > 5, 1);
        rdReg(DBWLM_OFS_CURRENT);
        check(rd, 0);
        wr(DBWLM_OFS_STATUS, 32'h1);
        act(3);
        tick(2);
        @(negedge clk_sys);
        check(errorIrq, 0);
        strobe(0);
        rdReg(DBWLM_OFS_CURRENT);
        check(rd, 10);
        act(4);
        strobe(1);
        rdReg(DBWLM_OFS_CURRENT);
        check(rd, 10);
        wr(DBWLM_OFS_BUDGET, DBWLM_BUDGET_OFF);
        wr(DBWLM_OFS_CFG, 32'h51);
        act(30);
        rdReg(DBWLM_OFS_STATUS);
        check({rd[7:0], errorIrq}, 0);
        engineReq <= 0;
        for (n = 0; n < 2; n++) begin
            workStartAddr <= ($random(seed) & 32'hFFFFFFE0) | (n * 8);
            strobe(2);
            tick(3);
            rdReg(DBWLM_OFS_STATUS);
            check({rd[7:4], errorIrq}, {n ? DBWLM_ERRC_ALIGN : DBWLM_ERRC_NONE, n[0]});
        end
        tally_and_finish();
    end
    initial begin
        #300000;
        err_count++;
        tally_and_finish();
    end
endmodule
bind dbwlm_channel dbwlm_properties CHK (.clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .workStart, .workActive,
    .engineReq, .reqAllowed, .xbarReq, .errorIrq);
